/* File: duc_core.sv */
// Serial frame receiver, register file and output update and preset control
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Load strobe low during whole frame updates output at frame select rising edge.
// - Load strobe high during frame holds code until later load strobe falling edge.
// - Reset pin or software reset bit returns device to power-on state, except the frame error flag.
// - Low preset input forces output to the 20-bit preset code.
// - After preset release output keeps preset value until a new load.
// - While preset input is low, no output update takes place.
// - Pulse register preset bit clears output to preset code like the pin.
// - Pulse register is write-only; a one acts as a low pin pulse.
// - Software preset ignored while load strobe pin is low.
// - Software load ignored while preset pin is low.
// - Preset code resets to zero and follows the selected coding.
// - Reset restores defaults, floats core, clamps output until configured otherwise.
// - Unclamped output shows current output code, zero code after reset.
// - Float and clamp bits select one of three output states.
// - Linearity trim field defaults to zero; host picks value by span.
// - Feedback resistor select bit set connects the compensation resistor pair.
// - Frame is 24 bits MSB first: read/write, three address, twenty data.
// - Frames with other than 24 falling serial clock edges are discarded.
// - A good write frame is written to its register at frame select rising edge.
module duc_core (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Serial link pins
   input  wire logic        frame_sel_n,
   input  wire logic        sclk,
   input  wire logic        serial_in,
   // Control pins
   input  wire logic        load_strobe_n,
   input  wire logic        output_preset_n,
   input  wire logic        reset_n,
   // Converter core controls
   output logic [19:0]      core_code_q,
   output duc_pkg::duc_out_mode_t out_mode_q,
   output logic             core_float_q,
   output logic             output_ground_clamp_q,
   output logic             feedback_resistor_select_q,
   output logic [3:0]       lin_trim_q,
   output logic             twos_coding_q,
   // Status
   output logic             frame_error_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   logic [duc_pkg::PIN_COUNT-1:0] pins_w;
   logic [duc_pkg::PIN_COUNT-1:0] prev_q;
   logic [duc_pkg::PIN_COUNT-1:0] prev_d;

   duc_sync #(
      .WIDTH      (duc_pkg::PIN_COUNT)
   ) u_sync (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .pin_in     ({reset_n, output_preset_n, load_strobe_n,
                    serial_in, sclk, frame_sel_n}),
      .pin_sync_q (pins_w)
   );

   logic frame_n_w;
   logic load_n_w;
   logic preset_n_w;
   logic rstn_w;
   logic frame_fall;
   logic frame_rise;
   logic sclk_fall;
   logic load_fall;

   assign frame_n_w  = pins_w[duc_pkg::PIN_FRAME_N];
   assign load_n_w   = pins_w[duc_pkg::PIN_LOAD_N];
   assign preset_n_w = pins_w[duc_pkg::PIN_PRESET_N];
   assign rstn_w     = pins_w[duc_pkg::PIN_RESET_N];
   assign frame_fall = prev_q[duc_pkg::PIN_FRAME_N] & ~frame_n_w;
   assign frame_rise = ~prev_q[duc_pkg::PIN_FRAME_N] & frame_n_w;
   assign sclk_fall  = prev_q[duc_pkg::PIN_SCLK] & ~pins_w[duc_pkg::PIN_SCLK];
   assign load_fall  = prev_q[duc_pkg::PIN_LOAD_N] & ~load_n_w;

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic [23:0] shift_q;
   logic [23:0] shift_d;
   logic [4:0]  cnt_q;
   logic [4:0]  cnt_d;
   logic        hold_low_q;
   logic        hold_low_d;
   logic [19:0] code_q;
   logic [19:0] code_d;
   logic [19:0] preset_q;
   logic [19:0] preset_d;
   logic [19:0] applied_q;
   logic [19:0] applied_d;
   logic        float_d;
   logic        clamp_d;
   logic        fb_sel_d;
   logic [3:0]  lin_d;
   logic        twos_d;
   logic        err_d;
   logic [19:0] core_code_d;
   duc_pkg::duc_out_mode_t out_mode_d;

   logic        frame_ok;
   logic        wr;
   logic [2:0]  addr;
   logic [19:0] data;
   logic [19:0] new_code;
   logic        sw_load;
   logic        sw_preset;
   logic        sw_reset;
   logic        load_req;
   logic        preset_req;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      prev_d      = pins_w;
      shift_d     = shift_q;
      cnt_d       = cnt_q;
      hold_low_d  = hold_low_q;
      code_d      = code_q;
      preset_d    = preset_q;
      applied_d   = applied_q;
      float_d     = core_float_q;
      clamp_d     = output_ground_clamp_q;
      fb_sel_d    = feedback_resistor_select_q;
      lin_d       = lin_trim_q;
      twos_d      = twos_coding_q;
      err_d       = frame_error_q;

      // Frame shift, MSB first, count saturates past 24
      if (frame_fall) begin
         cnt_d      = 5'h00;
         hold_low_d = ~load_n_w;
      end else if (!frame_n_w && sclk_fall) begin
         shift_d = {shift_q[22:0], pins_w[duc_pkg::PIN_SDATA]};
         if (cnt_q != duc_pkg::FRAME_OVER) begin
            cnt_d = cnt_q + 5'h01;
         end
      end
      if (!frame_n_w && load_n_w) begin
         hold_low_d = 1'b0;
      end

      // Frame decode at frame select rising edge
      frame_ok = frame_rise && (cnt_q == duc_pkg::FRAME_LEN);
      wr       = frame_ok && !shift_q[duc_pkg::FRAME_RW_BIT];
      addr     = shift_q[duc_pkg::FRAME_ADDR_LSB +: 3];
      data     = shift_q[duc_pkg::CODE_BITS-1:0];
      if (frame_rise) begin
         err_d = (cnt_q != duc_pkg::FRAME_LEN);
      end

      if (wr) begin
         unique case (addr)
            duc_pkg::ADDR_CODE:   code_d = data;
            duc_pkg::ADDR_PRESET: preset_d = data;
            duc_pkg::ADDR_CONFIG: begin
               fb_sel_d = data[duc_pkg::CFG_FB_SEL];
               clamp_d  = data[duc_pkg::CFG_CLAMP];
               float_d  = data[duc_pkg::CFG_FLOAT];
               twos_d   = data[duc_pkg::CFG_TWOS];
               lin_d    = data[duc_pkg::CFG_LIN_LSB +: duc_pkg::LIN_BITS];
            end
            default: ;
         endcase
      end

      // Pulse register bits act as pin pulses, nothing is stored
      sw_load   = wr && (addr == duc_pkg::ADDR_PULSE) && data[duc_pkg::PULSE_LOAD];
      sw_preset = wr && (addr == duc_pkg::ADDR_PULSE) && data[duc_pkg::PULSE_PRESET];
      sw_reset  = wr && (addr == duc_pkg::ADDR_PULSE) && data[duc_pkg::PULSE_RESET];

      // Output update and preset, preset has priority
      new_code   = (wr && addr == duc_pkg::ADDR_CODE) ? data : code_q;
      load_req   = (frame_ok && hold_low_q)
                 | (load_fall && frame_n_w && !frame_rise)
                 | sw_load;
      preset_req = !preset_n_w
                 | (sw_preset && load_n_w);
      if (preset_req) begin
         applied_d = preset_q;
      end else if (load_req) begin
         applied_d = new_code;
      end

      // Pin or software reset returns to power-on state, frame error flag kept
      if (!rstn_w || sw_reset) begin
         cnt_d      = duc_pkg::FRAME_OVER;
         hold_low_d = 1'b0;
         code_d     = duc_pkg::CODE_RESET;
         preset_d   = duc_pkg::PRESET_RESET;
         applied_d  = duc_pkg::CODE_RESET;
         float_d    = duc_pkg::FLOAT_RESET;
         clamp_d    = duc_pkg::CLAMP_RESET;
         fb_sel_d   = duc_pkg::FB_SEL_RESET;
         lin_d      = duc_pkg::LIN_RESET;
         twos_d     = duc_pkg::TWOS_RESET;
      end

      // Core code in offset binary, preset follows the same coding
      core_code_d = twos_d ? (applied_d ^ duc_pkg::CODE_SIGN_FLIP) : applied_d;

      // Three output states
      if (clamp_d) begin
         out_mode_d = duc_pkg::OM_CLAMP;
      end else if (float_d) begin
         out_mode_d = duc_pkg::OM_FLOAT;
      end else begin
         out_mode_d = duc_pkg::OM_NORMAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev_q                     <= '1;
         shift_q                    <= 24'h000000;
         cnt_q                      <= duc_pkg::FRAME_OVER;
         hold_low_q                 <= 1'b0;
         code_q                     <= duc_pkg::CODE_RESET;
         preset_q                   <= duc_pkg::PRESET_RESET;
         applied_q                  <= duc_pkg::CODE_RESET;
         core_float_q               <= duc_pkg::FLOAT_RESET;
         output_ground_clamp_q      <= duc_pkg::CLAMP_RESET;
         feedback_resistor_select_q <= duc_pkg::FB_SEL_RESET;
         lin_trim_q                 <= duc_pkg::LIN_RESET;
         twos_coding_q              <= duc_pkg::TWOS_RESET;
         frame_error_q              <= 1'b0;
         core_code_q                <= duc_pkg::CODE_RESET;
         out_mode_q                 <= duc_pkg::OM_CLAMP;
      end else begin
         prev_q                     <= prev_d;
         shift_q                    <= shift_d;
         cnt_q                      <= cnt_d;
         hold_low_q                 <= hold_low_d;
         code_q                     <= code_d;
         preset_q                   <= preset_d;
         applied_q                  <= applied_d;
         core_float_q               <= float_d;
         output_ground_clamp_q      <= clamp_d;
         feedback_resistor_select_q <= fb_sel_d;
         lin_trim_q                 <= lin_d;
         twos_coding_q              <= twos_d;
         frame_error_q              <= err_d;
         core_code_q                <= core_code_d;
         out_mode_q                 <= out_mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   property p_sync_update;
      frame_ok && hold_low_q && preset_n_w && rstn_w && !shift_q[23] && addr == duc_pkg::ADDR_CODE
      |=> applied_q == $past(shift_q[19:0]);
   endproperty
   a_sync_update: assert property (p_sync_update) else $error("sync update missed");

   property p_async_update;
      load_fall && frame_n_w && !frame_rise && preset_n_w && rstn_w
      |=> applied_q == $past(code_q);
   endproperty
   a_async_update: assert property (p_async_update) else $error("async update missed");

   property p_pin_reset;
      !rstn_w |=> code_q == duc_pkg::CODE_RESET && core_float_q && output_ground_clamp_q
                  ##1 out_mode_q == duc_pkg::OM_CLAMP;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");

   property p_preset_force;
      !preset_n_w && rstn_w && !sw_reset |=> applied_q == $past(preset_q);
   endproperty
   a_preset_force: assert property (p_preset_force) else $error("preset not forced");

   property p_preset_holds;
      !preset_n_w ##1 (preset_n_w && !load_req && rstn_w)[*2] |=> applied_q == $past(preset_q, 3);
   endproperty
   a_preset_holds: assert property (p_preset_holds) else $error("preset value lost");

   property p_bad_frame;
      frame_rise && cnt_q != duc_pkg::FRAME_LEN && rstn_w && !load_fall
      |=> frame_error_q && $stable(code_q) && $stable(preset_q);
   endproperty
   a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted");

   property p_reg_write;
      wr && addr == duc_pkg::ADDR_PRESET && rstn_w |=> preset_q == $past(data);
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("preset write lost");

   property p_rst_defaults;
      $fell(rst) |-> preset_q == duc_pkg::PRESET_RESET && lin_trim_q == duc_pkg::LIN_RESET
                     && core_float_q && output_ground_clamp_q;
   endproperty
   a_rst_defaults: assert property (p_rst_defaults) else $error("reset defaults wrong");

   property p_out_state;
      !output_ground_clamp_q |-> (out_mode_q == (core_float_q ? duc_pkg::OM_FLOAT : duc_pkg::OM_NORMAL));
   endproperty
   a_out_state: assert property (p_out_state) else $error("output state mismatch");

   property p_core_code;
      core_code_q == (twos_coding_q ? (applied_q ^ duc_pkg::CODE_SIGN_FLIP) : applied_q);
   endproperty
   a_core_code: assert property (p_core_code) else $error("core code mismatch");

   c_sync_update:  cover property (frame_ok && hold_low_q && preset_n_w);
   c_async_update: cover property (load_fall && frame_n_w && preset_n_w);
   c_sw_preset:    cover property (sw_preset && load_n_w);
   c_bad_frame:    cover property (frame_rise && cnt_q != duc_pkg::FRAME_LEN);

endmodule

`default_nettype wire

/* File: duc_pkg.sv */
// Constants and types shared by the converter update and preset control core
package duc_pkg;

   // Synchronised pin vector layout
   localparam int unsigned PIN_COUNT      = 6;
   localparam int unsigned PIN_FRAME_N    = 0;
   localparam int unsigned PIN_SCLK       = 1;
   localparam int unsigned PIN_SDATA      = 2;
   localparam int unsigned PIN_LOAD_N     = 3;
   localparam int unsigned PIN_PRESET_N   = 4;
   localparam int unsigned PIN_RESET_N    = 5;

   // Serial frame layout
   localparam int unsigned FRAME_BITS     = 24;
   localparam int unsigned CODE_BITS      = 20;
   localparam int unsigned FRAME_RW_BIT   = 23;
   localparam int unsigned FRAME_ADDR_LSB = 20;
   localparam logic [4:0]  FRAME_LEN      = 5'h18;
   localparam logic [4:0]  FRAME_OVER     = 5'h19;

   // Register addresses
   localparam logic [2:0]  ADDR_CODE      = 3'h1;
   localparam logic [2:0]  ADDR_CONFIG    = 3'h2;
   localparam logic [2:0]  ADDR_PRESET    = 3'h3;
   localparam logic [2:0]  ADDR_PULSE     = 3'h4;

   // Configuration register fields
   localparam int unsigned CFG_FB_SEL     = 1;
   localparam int unsigned CFG_CLAMP      = 2;
   localparam int unsigned CFG_FLOAT      = 3;
   localparam int unsigned CFG_TWOS       = 4;
   localparam int unsigned CFG_LIN_LSB    = 6;
   localparam int unsigned LIN_BITS       = 4;

   // Pulse register fields
   localparam int unsigned PULSE_LOAD     = 0;
   localparam int unsigned PULSE_PRESET   = 1;
   localparam int unsigned PULSE_RESET    = 2;

   // Reset values
   localparam logic [19:0] CODE_RESET     = 20'h00000;
   localparam logic [19:0] PRESET_RESET   = 20'h00000;
   localparam logic [3:0]  LIN_RESET      = 4'h0;
   localparam logic        FLOAT_RESET    = 1'b1;
   localparam logic        CLAMP_RESET    = 1'b1;
   localparam logic        FB_SEL_RESET   = 1'b0;
   localparam logic        TWOS_RESET     = 1'b0;

   // Twos complement to offset binary
   localparam logic [19:0] CODE_SIGN_FLIP = 20'h80000;

   typedef enum logic [1:0] {
      OM_NORMAL,
      OM_FLOAT,
      OM_CLAMP
   } duc_out_mode_t;

endpackage

/* File: duc_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module duc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Pins in, synchronised out
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta_q     <= '1;
         pin_sync_q <= '1;
      end else begin
         meta_q     <= pin_in;
         pin_sync_q <= meta_q;
      end
   end

endmodule

`default_nettype wire

/* File: duc_host_model.sv */
// Host model driving the serial frame pins of the converter core
`timescale 1ns/1ps
`default_nettype none

module duc_host_model (
   // Clock
   input  wire logic clk_sys,
   // Serial frame pins
   output logic      frame_sel_n,
   output logic      sclk,
   output logic      serial_in
);
   initial begin
      frame_sel_n = 1'b1;
      sclk        = 1'b0;
      serial_in   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One frame, half period of sclk given in clock cycles
   task automatic send_frame(input logic [23:0] word, input int n_edges, input int half);
      @(negedge clk_sys);
      frame_sel_n = 1'b0;
      repeat (half) @(negedge clk_sys);
      for (int i = 0; i < n_edges; i++) begin
         sclk      = 1'b1;
         serial_in = (i < 24) ? word[23 - i] : ~serial_in;
         repeat (half) @(negedge clk_sys);
         sclk = 1'b0;
         repeat (half) @(negedge clk_sys);
      end
      frame_sel_n = 1'b1;
      serial_in   = ~serial_in;
      repeat (4) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* File: dac_update_clear_control_tb_top.sv */
// Self-checking bench for the converter update and preset control core
`timescale 1ns/1ps
`default_nettype none

module dac_update_clear_control_tb_top;
   logic                   clk_sys;
   logic                   rst;
   logic                   frame_sel_n;
   logic                   sclk;
   logic                   serial_in;
   logic                   load_strobe_n;
   logic                   output_preset_n;
   logic                   reset_n;
   logic [19:0]            core_code_q;
   duc_pkg::duc_out_mode_t out_mode_q;
   logic                   core_float_q;
   logic                   output_ground_clamp_q;
   logic                   feedback_resistor_select_q;
   logic [3:0]             lin_trim_q;
   logic                   twos_coding_q;
   logic                   frame_error_q;
   logic [31:0]            seed;
   int                     n_fail;
   int                     samples_checked;
   int                     m_code, m_preset, m_out, m_lin, m_fl, m_cl, m_fb, m_tw, m_err, v;

   duc_core duc_core_i (.clk_sys(clk_sys), .rst(rst), .frame_sel_n(frame_sel_n), .sclk(sclk),
      .serial_in(serial_in), .load_strobe_n(load_strobe_n), .output_preset_n(output_preset_n),
      .reset_n(reset_n), .core_code_q(core_code_q), .out_mode_q(out_mode_q), .core_float_q(core_float_q),
      .output_ground_clamp_q(output_ground_clamp_q), .feedback_resistor_select_q(feedback_resistor_select_q),
      .lin_trim_q(lin_trim_q), .twos_coding_q(twos_coding_q), .frame_error_q(frame_error_q));

   duc_host_model duc_host_model_i (.clk_sys(clk_sys), .frame_sel_n(frame_sel_n), .sclk(sclk),
      .serial_in(serial_in));

   ////////////////////////////////////////////////////////////////////////////
   // Model helpers
   function automatic int rnd20();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h00000000);
      return int'(seed[19:0]);
   endfunction

   function automatic int cod(input int x);
      return (m_tw != 0) ? (x ^ int'(20'h80000)) : x;
   endfunction

   task automatic m_reset();
      m_code = 0; m_preset = 0; m_out = 0; m_lin = 0;
      m_fl = 1; m_cl = 1; m_fb = 0; m_tw = 0;
   endtask

   task automatic settle();
      repeat (5) @(negedge clk_sys);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Compare tasks
   task automatic chk_code();
      logic [19:0] exp;
      exp = 20'(cod(m_out));
      samples_checked++;
      if (core_code_q !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t code got %h exp %h", $time, core_code_q, exp);
      end
   endtask

   task automatic chk_ctl();
      logic [10:0] exp;
      logic [10:0] got;
      exp = {(m_cl != 0) ? duc_pkg::OM_CLAMP : (m_fl != 0) ? duc_pkg::OM_FLOAT : duc_pkg::OM_NORMAL,
             m_fl[0], m_cl[0], m_fb[0], m_lin[3:0], m_tw[0], m_err[0]};
      got = {out_mode_q, core_float_q, output_ground_clamp_q, feedback_resistor_select_q, lin_trim_q,
             twos_coding_q, frame_error_q};
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t control got %h exp %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Frame write with model update
   task automatic wr(input logic [2:0] addr, input int data, input int n_edges, input int half);
      duc_host_model_i.send_frame({1'b0, addr, data[19:0]}, n_edges, half);
      m_err = (n_edges != 24);
      if (n_edges == 24) begin
         case (addr)
            duc_pkg::ADDR_CODE: begin
               m_code = data & 'hFFFFF;
               if (!load_strobe_n && output_preset_n) m_out = m_code;
            end
            duc_pkg::ADDR_CONFIG: begin
               m_fb = data[1]; m_cl = data[2]; m_fl = data[3]; m_tw = data[4]; m_lin = data[9:6];
            end
            duc_pkg::ADDR_PRESET: m_preset = data & 'hFFFFF;
            duc_pkg::ADDR_PULSE: begin
               if (data[0] && output_preset_n) m_out = m_code;
               if (data[1] && load_strobe_n) m_out = m_preset;
               if (data[2]) m_reset();
            end
            default: ;
         endcase
      end
      settle();
   endtask

   task automatic load_pulse();
      load_strobe_n = 1'b0;
      if (output_preset_n) m_out = m_code;
      settle();
      chk_code();
      load_strobe_n = 1'b1;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      $display("[FAIL] t=%0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      rst = 1'b1; load_strobe_n = 1'b1; output_preset_n = 1'b1; reset_n = 1'b1;
      seed = 32'h0001418C; n_fail = 0; samples_checked = 0; m_err = 0;
      m_reset();
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_code();
      chk_ctl();
      $display("test defaults done");
      for (int i = 3; i >= 0; i--) begin
         wr(duc_pkg::ADDR_CONFIG, i << 2, 24, 8);
         chk_ctl();
      end
      wr(duc_pkg::ADDR_CONFIG, 'h302, 24, 8);
      chk_ctl();
      chk_code();
      $display("test config done");
      load_strobe_n = 1'b0;
      wr(duc_pkg::ADDR_CODE, rnd20(), 24, 8);
      chk_code();
      load_strobe_n = 1'b1;
      wr(duc_pkg::ADDR_CODE, rnd20(), 24, 8);
      chk_code();
      load_pulse();
      $display("test updates done");
      for (int n = 23; n <= 25; n += 2) begin
         wr(duc_pkg::ADDR_CODE, rnd20(), n, 8);
         chk_ctl();
         load_pulse();
      end
      $display("test bad frames done");
      wr(duc_pkg::ADDR_PRESET, rnd20(), 24, 8);
      output_preset_n = 1'b0;
      m_out = m_preset;
      settle();
      chk_code();
      wr(duc_pkg::ADDR_CODE, rnd20(), 24, 8);
      load_pulse();
      wr(duc_pkg::ADDR_PULSE, 1, 24, 8);
      chk_code();
      output_preset_n = 1'b1;
      settle();
      chk_code();
      load_pulse();
      wr(duc_pkg::ADDR_PULSE, 2, 24, 8);
      chk_code();
      wr(duc_pkg::ADDR_PULSE, 1, 24, 8);
      chk_code();
      load_strobe_n = 1'b0;
      wr(duc_pkg::ADDR_PULSE, 2, 24, 8);
      chk_code();
      load_strobe_n = 1'b1;
      $display("test preset done");
      wr(duc_pkg::ADDR_CONFIG, 'h10, 24, 8);
      chk_ctl();
      chk_code();
      wr(duc_pkg::ADDR_CODE, rnd20(), 24, 8);
      load_pulse();
      wr(duc_pkg::ADDR_PULSE, 2, 24, 8);
      chk_code();
      wr(duc_pkg::ADDR_PULSE, 4, 24, 8);
      chk_code();
      chk_ctl();
      $display("test coding and soft reset done");
      wr(duc_pkg::ADDR_CONFIG, 'h142, 24, 8);
      v = rnd20();
      fork
         duc_host_model_i.send_frame({1'b0, duc_pkg::ADDR_CODE, v[19:0]}, 24, 8);
         begin
            repeat (100) @(negedge clk_sys);
            reset_n = 1'b0;
         end
      join
      m_reset();
      settle();
      reset_n = 1'b1;
      settle();
      chk_code();
      m_err = 1;
      chk_ctl();
      wr(duc_pkg::ADDR_PRESET, rnd20(), 24, 8);
      chk_ctl();
      $display("test reset pin done");
      summarize();
   end
endmodule
`default_nettype wire
